/* File: ccp_deadtime.sv */
// dead-time generator making a complementary output pair from one pwm level
`timescale 1ns/1ps
module ccp_deadtime (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic enable,
   input wire logic [1:0] prescale,
   input wire logic [5:0] dead_count,
   input wire logic level,
   output ccp_pkg::ccp_dt_s pair
);
   import ccp_pkg::*;
   logic [2:0] pre_r;
   logic [5:0] cnt_r;
   logic last_r;
   logic hi_r;
   logic lo_r;
   logic [2:0] pre_mask;
   logic tick;
   logic bypass;

   // code 11 divides by eight, the widest prescale
   assign pre_mask = (prescale == 2'h0) ? 3'h0 : (prescale == 2'h1) ? 3'h1 :
                     (prescale == 2'h2) ? 3'h3 : 3'h7;
   assign tick = (pre_r & pre_mask) == pre_mask;
   assign bypass = !enable || (dead_count == 6'h00);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_r <= 3'h0;
         cnt_r <= 6'h00;
         last_r <= 1'h0;
         hi_r <= 1'h0;
         lo_r <= 1'h0;
      end else begin
         pre_r <= pre_r + 3'h1;
         last_r <= level;
         if (bypass) begin
            cnt_r <= 6'h00;
            hi_r <= level;
            lo_r <= ~level;
         end else if (level != last_r) begin
            // both sides off for the whole dead period
            cnt_r <= dead_count;
            hi_r <= 1'h0;
            lo_r <= 1'h0;
         end else if (cnt_r != 6'h00) begin
            if (tick) cnt_r <= cnt_r - 6'h01;
         end else begin
            hi_r <= level;
            lo_r <= ~level;
         end
      end
   end

   assign pair.hi = hi_r;
   assign pair.lo = lo_r;
endmodule

/* File: ccp_defines.svh */
// register indices, field positions, reset values and masks of the compare/capture array
// Operation
// - rise, fall or both edges select capture
// - capture loads base counter into capture bytes
// - interrupt request when flag and enable set
// - modules six and seven never capture
// - odd module buffers even module captures
// - compare match sets flag in timer mode
// - fast toggle output inverts pin on match
// - pwm mode, shared base counter frequency
// - 8-bit pwm low while counter below compare
// - 9-bit compare reloaded on low byte wrap
// - zero gives full high, ninth bit none
// - each channel selects its own resolution
// - buffered wide pwm applies both bytes together
// - toggle on selected-resolution pwm match
// - pair sets rising and falling edge positions
// - duty chain steps on selected overflow
// - two-bit field selects chain step source
// - dead time only modules 0/2/4 buffered
// - dead-time prescale of 1, 2, 4 or 8
// - dead time counts 0 to 63 periods
// - resolution field and overflow on wrap
// - hardware sets flag, software clears it
`ifndef CCP_DEFINES_SVH
`define CCP_DEFINES_SVH
`define CCP_NMOD 8
`define CCP_IDX_FSEL 8'ha4
`define CCP_IDX_DTC 8'hbc
`define CCP_IDX_MODE0 8'hda
`define CCP_IDX_HI0 8'hc0
`define CCP_IDX_LO0 8'hc8
`define CCP_IDX_AUX0 8'hd0
`define CCP_IDX_BME 8'hd8
`define CCP_RST_BYTE 8'h00
`define CCP_AUX_MASK 8'hcf
`define CCP_FSEL_MASK 8'h3f
`define CCP_FLAG_BIT 3
`define CCP_INV_BIT 2
`define CCP_ECAPH_BIT 1
`define CCP_ECAPL_BIT 0
`define CCP_RES_MSB 7
`define CCP_RES_LSB 6
`define CCP_FSEL_MSB 3
`define CCP_FSEL_LSB 2
`define CCP_MASK8 16'h00ff
`define CCP_MASK10 16'h03ff
`define CCP_MASK12 16'h0fff
`define CCP_MASK16 16'hffff
`define CCP_DT_MSB 5
`define CCP_PS_MSB 7
`define CCP_PS_LSB 6
`endif

/* File: ccp_edge.sv */
// two-flop synchroniser and edge detector for one capture pin
`timescale 1ns/1ps
module ccp_edge (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pin_raw,
   output logic rise,
   output logic fall
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   // first flop feeds only the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_r <= 1'h0;
         sync_r <= 1'h0;
         prev_r <= 1'h0;
      end else begin
         meta_r <= pin_raw;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;
endmodule

/* File: ccp_monitor.sv */
// port-level assertions of the compare/capture array
`timescale 1ns/1ps
module ccp_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [7:0] base_counter_high,
   input wire logic [7:0] base_counter_low,
   input wire logic timer0_overflow,
   input wire logic timer1_overflow,
   input wire logic timer3_overflow,
   input wire logic serial0_timer_overflow,
   input wire logic [7:0] module_io_pin_out,
   input wire logic [7:0] module_io_pin_oe,
   input wire logic [7:0] module_irq,
   input wire ccp_pkg::ccp_dt_s [2:0] dead_time_pair
);
   import ccp_pkg::*;
   logic wr_dp_r, rd_dp_r, chg_r, evt_r;
   logic [15:0] cnt_r;
   wire taken = hsel & htrans[1] & hready;
   wire [15:0] cnt = {base_counter_high, base_counter_low};
   // pin outputs may only move after a bus write, a counter step or any timer overflow
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_dp_r <= 1'h0;
         rd_dp_r <= 1'h0;
         chg_r <= 1'h0;
         evt_r <= 1'h0;
         cnt_r <= 16'h0000;
      end else begin
         evt_r <= timer0_overflow | timer1_overflow | timer3_overflow | serial0_timer_overflow;
         wr_dp_r <= taken & hwrite;
         rd_dp_r <= taken & ~hwrite;
         chg_r <= cnt != cnt_r;
         cnt_r <= cnt;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_rd_req;
      taken && !hwrite;
   endsequence
   sequence s_rd_ans;
      !hreadyout ##1 hreadyout;
   endsequence
   AST_RD_WAIT: assert property (s_rd_req |=> s_rd_ans)
      else $error("read data phase not one wait state");
   AST_WR_READY: assert property (taken && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   AST_OKAY: assert property (hresp == 1'h0)
      else $error("response not okay");
   AST_RDATA_HOLD: assert property ($changed(hrdata) |-> $past(rd_dp_r) || $past(rd_dp_r, 2))
      else $error("read data moved without a read");
   AST_PIN_CAUSE: assert property ($changed(module_io_pin_out) |->
      chg_r || $past(chg_r) || $past(evt_r) || $past(wr_dp_r) || $past(wr_dp_r, 2))
      else $error("pin moved without counter step or write");
   AST_OE_CAUSE: assert property ($changed(module_io_pin_oe) |->
      $past(wr_dp_r) || $past(wr_dp_r, 2))
      else $error("pin enable moved without a write");
   AST_FLAG_CLEAR: assert property ((($past(module_irq) & ~module_irq) != 8'h00) |->
      $past(wr_dp_r) || $past(wr_dp_r, 2))
      else $error("request dropped without software");
   AST_DT_EXCL: assert property (!(dead_time_pair[0] == 2'h3 ||
      dead_time_pair[1] == 2'h3 || dead_time_pair[2] == 2'h3))
      else $error("both sides of a pair on");
endmodule

/* File: ccp_pin_model.sv */
// far-side capture sources that switch after a chosen lag
`timescale 1ns/1ps
module ccp_pin_model (
   input wire logic hclk,
   input wire logic [7:0] level_req,
   input wire logic [1:0] lag,
   output logic [7:0] pin
);
   logic [3:0][7:0] st_r = '0;
   always @(posedge hclk) st_r <= {st_r[2:0], level_req};
   // changes land on the falling edge, unrelated to the sampling edge
   always @(negedge hclk) pin <= st_r[lag];
endmodule

/* File: ccp_pkg.sv */
// types and shared decode functions of the compare/capture array
`include "ccp_defines.svh"
package ccp_pkg;
   typedef struct packed {
      logic dte;
      logic ecom;
      logic capp;
      logic capn;
      logic mat;
      logic tog;
      logic pwm;
      logic eccf;
   } ccp_mode_s;

   typedef struct packed {
      logic hi;
      logic lo;
   } ccp_dt_s;

   typedef enum logic [2:0] {FN_NONE, FN_CAP, FN_TIMER, FN_HSO, FN_PWM, FN_TOGGLE_ON_PULSE_MATCH, FN_FIFO}
      ccp_func_e;

   function automatic ccp_func_e ccp_decode(input ccp_mode_s m, input logic cap_ok);
      ccp_func_e f;
      f = FN_NONE;
      if (cap_ok && (m.capp || m.capn) && !m.mat && !m.tog && !m.pwm) f = FN_CAP;
      else if (m.ecom && !m.capp && !m.capn && m.mat && !m.pwm) f = m.tog ? FN_HSO : FN_TIMER;
      else if (m.ecom && !m.capp && !m.capn && !m.mat && m.pwm) f = m.tog ? FN_TOGGLE_ON_PULSE_MATCH : FN_PWM;
      else if (m.ecom && !m.capp && m.capn && !m.mat && !m.tog && m.pwm) f = FN_FIFO;
      return f;
   endfunction

   function automatic logic [15:0] ccp_mask(input logic [1:0] res);
      logic [15:0] mk;
      mk = (res == 2'h0) ? `CCP_MASK8 : (res == 2'h1) ? `CCP_MASK10 :
           (res == 2'h2) ? `CCP_MASK12 : `CCP_MASK16;
      return mk;
   endfunction

   function automatic logic ccp_wrap(input logic [15:0] mk, input logic [15:0] prev,
                                     input logic [15:0] cur);
      return ((prev & mk) == mk) && ((cur & mk) == 16'h0000);
   endfunction

   function automatic logic ccp_hit(input logic [7:0] idx, input logic [7:0] target);
      return idx == target;
   endfunction
endpackage

/* File: ccp_top.sv */
// compare/capture array mode logic with its ahb-lite register slave
`timescale 1ns/1ps
`include "ccp_defines.svh"
module ccp_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [7:0] base_counter_high,
   input wire logic [7:0] base_counter_low,
   input wire logic timer0_overflow,
   input wire logic timer1_overflow,
   input wire logic timer3_overflow,
   input wire logic serial0_timer_overflow,
   input wire logic [7:0] module_io_pin_in,
   output logic [7:0] module_io_pin_out,
   output logic [7:0] module_io_pin_oe,
   output logic [7:0] module_irq,
   output ccp_pkg::ccp_dt_s [2:0] dead_time_pair
);
   import ccp_pkg::*;

   localparam int NM = `CCP_NMOD;

   // register file
   ccp_mode_s mode_r [NM];
   logic [7:0] lo_r [NM];
   logic [7:0] hi_r [NM];
   logic [7:0] aux_r [NM];
   logic [15:0] act_r [NM];
   logic [1:0] step_r [NM];
   logic [7:0] lvl_r;
   logic [7:0] fsel_r;
   logic [7:0] dtc_r;
   logic [2:0] bme_r;

   // bus state
   logic dph_wr_r;
   logic rd_wait_r;
   logic [7:0] idx_r;
   logic idx_ok_r;
   logic [31:0] hrdata_r;
   logic [7:0] rd_byte;

   // shared timing
   logic [15:0] count;
   logic [15:0] cnt_prev_r;
   logic cnt_step;
   logic chain_step_event;
   logic [7:0] rise;
   logic [7:0] fall;
   logic [7:0] cap_ev_v;
   logic [7:0] pwm_eq_v;

   // named bus decode
   logic aph;
   logic wr_ok;
   logic [7:0] wbyte;

   assign count = {base_counter_high, base_counter_low};
   // matches count once per counter value, not per system clock
   assign cnt_step = count != cnt_prev_r;

   assign aph = hsel & htrans[1] & hready;
   assign wr_ok = dph_wr_r & idx_ok_r;
   assign wbyte = hwdata[7:0];

   // zero-wait writes, one wait state on reads so read data leaves a flop
   assign hreadyout = ~rd_wait_r;
   assign hresp = 1'h0;
   assign hrdata = hrdata_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr_r <= 1'h0;
         rd_wait_r <= 1'h0;
         idx_r <= 8'h00;
         idx_ok_r <= 1'h0;
         hrdata_r <= 32'h0000_0000;
         cnt_prev_r <= 16'h0000;
      end else begin
         dph_wr_r <= aph & hwrite;
         rd_wait_r <= aph & ~hwrite;
         if (aph) begin
            idx_r <= haddr[9:2];
            idx_ok_r <= (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'h0);
         end
         if (rd_wait_r) hrdata_r <= {24'h00_0000, rd_byte};
         cnt_prev_r <= count;
      end
   end

   // read select, unmapped indices read zero
   always_comb begin
      rd_byte = 8'h00;
      if (idx_ok_r) begin
         if (ccp_hit(idx_r, `CCP_IDX_FSEL)) rd_byte = fsel_r;
         if (ccp_hit(idx_r, `CCP_IDX_DTC)) rd_byte = dtc_r;
         if (ccp_hit(idx_r, `CCP_IDX_BME)) rd_byte = {5'h00, bme_r};
         for (int n = 0; n < NM; n++) begin
            if (ccp_hit(idx_r, 8'(`CCP_IDX_MODE0 + n))) rd_byte = mode_r[n];
            if (ccp_hit(idx_r, 8'(`CCP_IDX_LO0 + n))) rd_byte = lo_r[n];
            if (ccp_hit(idx_r, 8'(`CCP_IDX_HI0 + n))) rd_byte = hi_r[n];
            if (ccp_hit(idx_r, 8'(`CCP_IDX_AUX0 + n))) rd_byte = aux_r[n];
         end
      end
   end

   // array-wide control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fsel_r <= `CCP_RST_BYTE;
         dtc_r <= `CCP_RST_BYTE;
         bme_r <= 3'h0;
      end else begin
         if (wr_ok && ccp_hit(idx_r, `CCP_IDX_FSEL)) fsel_r <= wbyte & `CCP_FSEL_MASK;
         if (wr_ok && ccp_hit(idx_r, `CCP_IDX_DTC)) dtc_r <= wbyte;
         if (wr_ok && ccp_hit(idx_r, `CCP_IDX_BME)) bme_r <= wbyte[2:0];
      end
   end

   // duty-chain step source
   assign chain_step_event =
      (fsel_r[`CCP_FSEL_MSB:`CCP_FSEL_LSB] == 2'h0) ? timer0_overflow :
      (fsel_r[`CCP_FSEL_MSB:`CCP_FSEL_LSB] == 2'h1) ? timer1_overflow :
      (fsel_r[`CCP_FSEL_MSB:`CCP_FSEL_LSB] == 2'h2) ? timer3_overflow :
      serial0_timer_overflow;

   for (genvar n = 0; n < NM; n++) begin : g_mod
      localparam logic CAP_OK = (n < 6);
      localparam int PK = (n < 6) ? n / 2 : 0;
      localparam int PN = n ^ 1;
      localparam int PV = (n > 0) ? n - 1 : 0;
      localparam int NX = (n == NM - 1) ? n : n + 1;
      localparam logic IS_ODD = (n % 2 == 1);

      ccp_func_e fn;
      logic pair_buf;
      logic [15:0] mk;
      logic [15:0] cmp16;
      logic res8;
      logic ovf;
      logic eq16;
      logic cmp_ev;
      logic buf_ev;
      logic reload8;
      logic [16:0] cnt_m;
      logic [16:0] pwm_val;
      logic pwm_low;
      logic pwm_eq;
      logic [7:0] duty;
      logic fifo_low;
      logic we_mode;
      logic we_lo;
      logic we_hi;
      logic we_aux;
      logic flag_set;

      ccp_edge u_edge (
         .hclk(hclk),
         .hresetn(hresetn),
         .pin_raw(module_io_pin_in[n]),
         .rise(rise[n]),
         .fall(fall[n])
      );

      assign fn = ccp_decode(mode_r[n], CAP_OK);
      assign pair_buf = CAP_OK & bme_r[PK];
      assign mk = ccp_mask(aux_r[n][`CCP_RES_MSB:`CCP_RES_LSB]);
      assign cmp16 = {hi_r[n], lo_r[n]};
      assign res8 = aux_r[n][`CCP_RES_MSB:`CCP_RES_LSB] == 2'h0;
      assign ovf = ccp_wrap(mk, cnt_prev_r, count);

      assign cap_ev_v[n] = (fn == FN_CAP) &
         ((mode_r[n].capp & rise[n]) | (mode_r[n].capn & fall[n]));
      assign buf_ev = IS_ODD & pair_buf & cap_ev_v[PV];

      assign eq16 = cnt_step && (count == cmp16);
      assign cmp_ev = ((fn == FN_TIMER) || (fn == FN_HSO)) && eq16;

      // wide modes compare the masked counter, buffered ones a snapshot
      assign cnt_m = {1'h0, count & mk};
      assign pwm_val = res8 ? {8'h00, aux_r[n][`CCP_ECAPL_BIT], lo_r[n]} :
         {1'h0, pair_buf ? act_r[n] : (cmp16 & mk)};
      assign pwm_low = cnt_m < pwm_val;
      assign pwm_eq = cnt_step && (cnt_m == pwm_val);
      assign pwm_eq_v[n] = pwm_eq;
      assign reload8 = res8 && ovf && ((fn == FN_PWM) || (fn == FN_TOGGLE_ON_PULSE_MATCH));

      assign duty = (step_r[n] == 2'h0) ? lo_r[n] : (step_r[n] == 2'h1) ? hi_r[n] :
                    (step_r[n] == 2'h2) ? lo_r[NX] : hi_r[NX];
      assign fifo_low = base_counter_low < duty;

      assign we_mode = wr_ok && ccp_hit(idx_r, 8'(`CCP_IDX_MODE0 + n));
      assign we_lo = wr_ok && ccp_hit(idx_r, 8'(`CCP_IDX_LO0 + n));
      assign we_hi = wr_ok && ccp_hit(idx_r, 8'(`CCP_IDX_HI0 + n));
      assign we_aux = wr_ok && ccp_hit(idx_r, 8'(`CCP_IDX_AUX0 + n));
      assign flag_set = cap_ev_v[n] | cmp_ev;

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) mode_r[n] <= `CCP_RST_BYTE;
         else if (we_mode) mode_r[n] <= wbyte;
      end

      // hardware loads win over a software write in the same cycle
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            lo_r[n] <= `CCP_RST_BYTE;
            hi_r[n] <= `CCP_RST_BYTE;
         end else if (cap_ev_v[n]) begin
            lo_r[n] <= base_counter_low;
            hi_r[n] <= base_counter_high;
         end else if (buf_ev) begin
            lo_r[n] <= lo_r[PV];
            hi_r[n] <= hi_r[PV];
         end else begin
            if (reload8) lo_r[n] <= hi_r[n];
            else if (we_lo) lo_r[n] <= wbyte;
            if (we_hi) hi_r[n] <= wbyte;
         end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            aux_r[n] <= `CCP_RST_BYTE;
         end else begin
            if (we_aux) aux_r[n] <= wbyte & `CCP_AUX_MASK;
            if (reload8) aux_r[n][`CCP_ECAPL_BIT] <= aux_r[n][`CCP_ECAPH_BIT];
            if (flag_set) aux_r[n][`CCP_FLAG_BIT] <= 1'h1;
         end
      end

      // both bytes move together at the period boundary
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) act_r[n] <= 16'h0000;
         else if (ovf) act_r[n] <= cmp16 & mk;
      end

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) step_r[n] <= 2'h0;
         else if (fn != FN_FIFO) step_r[n] <= 2'h0;
         else if (chain_step_event) step_r[n] <= step_r[n] + 2'h1;
      end

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            lvl_r[n] <= 1'h0;
         end else begin
            unique case (fn)
               FN_NONE, FN_CAP, FN_TIMER: lvl_r[n] <= lvl_r[n];
               FN_HSO: if (eq16) lvl_r[n] <= ~lvl_r[n];
               FN_PWM: lvl_r[n] <= ~pwm_low;
               FN_TOGGLE_ON_PULSE_MATCH: begin
                  // even module of a buffered pair: own match rises, partner falls
                  if (!IS_ODD && pair_buf) begin
                     if (pwm_eq) lvl_r[n] <= 1'h1;
                     else if (pwm_eq_v[PN]) lvl_r[n] <= 1'h0;
                  end else if (pwm_eq) begin
                     lvl_r[n] <= ~lvl_r[n];
                  end
               end
               FN_FIFO: lvl_r[n] <= ~fifo_low;
            endcase
         end
      end

      assign module_io_pin_out[n] = lvl_r[n] ^ aux_r[n][`CCP_INV_BIT];
      assign module_io_pin_oe[n] = (fn == FN_HSO) || (fn == FN_PWM) ||
                                   (fn == FN_TOGGLE_ON_PULSE_MATCH) || (fn == FN_FIFO);
      assign module_irq[n] = aux_r[n][`CCP_FLAG_BIT] & mode_r[n].eccf;
   end

   for (genvar k = 0; k < 3; k++) begin : g_dt
      logic dt_en;
      assign dt_en = mode_r[2 * k].dte & bme_r[k];
      ccp_deadtime u_dt (
         .hclk(hclk),
         .hresetn(hresetn),
         .enable(dt_en),
         .prescale(dtc_r[`CCP_PS_MSB:`CCP_PS_LSB]),
         .dead_count(dtc_r[`CCP_DT_MSB:0]),
         .level(module_io_pin_out[2 * k]),
         .pair(dead_time_pair[k])
      );
   end
endmodule

/* File: tb_top.sv */
// self-checking bench of the compare/capture array
`timescale 1ns/1ps
`include "ccp_defines.svh"
module tb_top;
   import ccp_pkg::*;
   localparam logic [7:0] i_md = `CCP_IDX_MODE0, i_lo = `CCP_IDX_LO0;
   localparam logic [7:0] i_hi = `CCP_IDX_HI0, i_ax = `CCP_IDX_AUX0;
   logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
   logic [1:0] htrans = 2'h0, pin_lag = 2'h0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
   logic [15:0] cnt = 16'h0000;
   logic [3:0] ovf = 4'h0;
   logic [7:0] pin_req = 8'h00;
   wire hready, hreadyout, hresp;
   wire [7:0] pins, pin_out, pin_oe, irq;
   wire [31:0] hrdata;
   wire ccp_dt_s [2:0] dtp;
   int fails = 0;
   int samples_checked = 0;
   always #20 hclk = ~hclk;
   assign hready = hreadyout;
   ccp_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .base_counter_high(cnt[15:8]),
      .base_counter_low(cnt[7:0]), .timer0_overflow(ovf[0]), .timer1_overflow(ovf[1]),
      .timer3_overflow(ovf[2]), .serial0_timer_overflow(ovf[3]), .module_io_pin_in(pins),
      .module_io_pin_out(pin_out), .module_io_pin_oe(pin_oe), .module_irq(irq),
      .dead_time_pair(dtp));
   ccp_pin_model u_pins (.hclk(hclk), .level_req(pin_req), .lag(pin_lag), .pin(pins));
   task automatic report_and_stop();
      if (fails == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic ready_wait(inout int n);
      @(negedge hclk);
      while (hreadyout !== 1'h1 && n < 50) begin
         n++;
         @(negedge hclk);
      end
   endtask
   // whole-word single transfer; address held until ready seen
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
      output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h00_0000, idx, 2'h0};
      ready_wait(n);
      @(posedge hclk);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, wd};
      ready_wait(n);
      rd = hrdata;
      @(posedge hclk);
      // half a cycle on, so callers never read outputs in the launching time step
      @(negedge hclk);
      if (n >= 50) begin
         fails++;
         report_and_stop();
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] v;
      bus(1'h1, idx, d, v);
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
      logic [31:0] v;
      bus(1'h0, idx, 8'h00, v);
      chk(v, {24'h00_0000, e});
   endtask
   task automatic drive(input logic [15:0] c, input logic [7:0] pr);
      @(posedge hclk);
      cnt <= c;
      pin_req <= pr;
   endtask
   task automatic wait_irq(input int b);
      int n;
      n = 0;
      @(negedge hclk);
      while (irq[b] !== 1'h1 && n < 20) begin
         n++;
         @(negedge hclk);
      end
      chk(irq[b], 1'h1);
      if (irq[b] !== 1'h1) report_and_stop();
   endtask
   task automatic t_regs();
      chk(pin_oe, 8'h00);
      rdc(i_md, 8'h00);
      wr(`CCP_IDX_FSEL, 8'hff);
      rdc(`CCP_IDX_FSEL, 8'h3f);
      for (int k = 0; k < 4; k++) begin
         wr(`CCP_IDX_FSEL, 8'(k * 4));
         rdc(`CCP_IDX_FSEL, 8'(k * 4));
      end
      wr(`CCP_IDX_DTC, 8'hc5);
      rdc(`CCP_IDX_DTC, 8'hc5);
      wr(8'h10, 8'hff);
      rdc(8'h10, 8'h00);
      wr(i_ax, 8'hc7);
      rdc(i_ax, 8'hc7);
      wr(i_ax, 8'h00);
   endtask
   task automatic t_capture();
      wr(i_md, 8'h21);
      drive(16'h1234, 8'h01);
      wait_irq(0);
      rdc(i_lo, 8'h34);
      rdc(i_hi, 8'h12);
      drive(16'h5678, 8'h00);
      repeat (8) @(negedge hclk);
      rdc(i_lo, 8'h34);
      wr(i_ax, 8'h00);
      chk(irq[0], 1'h0);
      wr(`CCP_IDX_BME, 8'h01);
      wr(i_md, 8'h31);
      drive(16'h5678, 8'h01);
      pin_lag <= 2'h3;
      wait_irq(0);
      wr(i_ax, 8'h00);
      drive(16'h00ab, 8'h00);
      wait_irq(0);
      rdc(i_lo, 8'hab);
      rdc(i_lo + 8'h1, 8'h78);
      rdc(i_hi + 8'h1, 8'h56);
      wr(i_md + 8'h6, 8'h11);
      drive(16'h00ab, 8'h40);
      repeat (8) @(negedge hclk);
      drive(16'h00ab, 8'h00);
      repeat (8) @(negedge hclk);
      chk(irq[6], 1'h0);
      rdc(i_lo + 8'h6, 8'h00);
      wr(i_md, 8'h00);
      wr(i_md + 8'h6, 8'h00);
      wr(`CCP_IDX_BME, 8'h00);
      wr(i_ax, 8'h00);
   endtask
   // module 2 in 8-bit pwm beside module 3 in live 10-bit pwm
   task automatic t_pwm();
      logic [8:0] duty [3];
      logic [15:0] p;
      duty = '{9'h040, 9'h100, 9'h000};
      wr(i_hi + 8'h3, 8'h02);
      wr(i_ax + 8'h3, 8'h40);
      wr(i_md + 8'h3, 8'h42);
      for (int k = 0; k < 3; k++) begin
         wr(i_hi + 8'h2, duty[k][7:0]);
         wr(i_ax + 8'h2, {6'h00, duty[k][8], 1'h0});
         wr(i_md + 8'h2, 8'h42);
         chk(pin_oe[3:2], 2'h3);
         for (int c = 1; c < 1280; c++) begin
            @(posedge hclk);
            cnt <= c[15:0];
            @(negedge hclk);
            p = c[15:0] - 16'h0001;
            if (c > 258 && p[7:0] > 8'h01) chk(pin_out[2], {1'h0, p[7:0]} >= duty[k]);
            if (p[9:0] > 10'h001) chk(pin_out[3], p[9:0] >= 10'h200);
         end
      end
      wr(i_md + 8'h2, 8'h00);
      wr(i_md + 8'h3, 8'h00);
   endtask
   task automatic t_hso();
      logic v;
      wr(i_lo + 8'h4, 8'h10);
      wr(i_md + 8'h4, 8'h4d);
      wr(i_lo + 8'h5, 8'h18);
      wr(i_md + 8'h5, 8'h49);
      @(negedge hclk);
      v = pin_out[4];
      for (int c = 0; c < 24; c++) drive(c[15:0], 8'h00);
      repeat (2) @(negedge hclk);
      chk(irq[5], 1'h0);
      for (int c = 24; c < 32; c++) drive(c[15:0], 8'h00);
      repeat (2) @(negedge hclk);
      chk(pin_out[4], !v);
      chk(irq[4], 1'h1);
      chk(irq[5], 1'h1);
      chk({pin_oe[5], pin_out[5]}, 2'h0);
      wr(i_ax + 8'h4, 8'h00);
      chk(irq[4], 1'h0);
      wr(i_md + 8'h4, 8'h00);
      wr(i_md + 8'h5, 8'h00);
   endtask
   // buffered pair 0/1: module 0 rises on its own match, falls on module 1's
   task automatic t_toggle_on_pulse_match();
      logic [7:0] p;
      wr(`CCP_IDX_DTC, 8'h43);
      wr(`CCP_IDX_BME, 8'h01);
      wr(i_lo, 8'h20);
      wr(i_hi, 8'h20);
      wr(i_lo + 8'h1, 8'h60);
      wr(i_md, 8'hc6);
      for (int c = 1; c < 128; c++) begin
         @(posedge hclk);
         cnt <= c[15:0];
         @(negedge hclk);
         p = 8'(c - 1);
         chk(pin_out[0], p >= 8'h20 && p < 8'h60);
         if (p == 8'h21 || p == 8'h22) chk(dtp[0], 2'h0);
         if (p == 8'h30) chk(dtp[0], 2'h2);
      end
      wr(i_md, 8'h00);
      wr(`CCP_IDX_BME, 8'h00);
   endtask
   // module 2 walks its duty chain on timer 1 overflow only
   task automatic t_fifo();
      logic [7:0] d [4];
      d = '{8'h40, 8'h80, 8'h30, 8'hf0};
      wr(`CCP_IDX_FSEL, 8'h04);
      wr(i_lo + 8'h2, d[0]);
      wr(i_hi + 8'h2, d[1]);
      wr(i_lo + 8'h3, d[2]);
      wr(i_hi + 8'h3, d[3]);
      drive(16'h0050, 8'h00);
      wr(i_md + 8'h2, 8'h52);
      for (int k = 0; k < 5; k++) begin
         @(posedge hclk);
         ovf <= (k == 0) ? 4'h1 : 4'h2;
         @(posedge hclk);
         ovf <= 4'h0;
         repeat (2) @(negedge hclk);
         chk(pin_out[2], 8'h50 >= d[k % 4]);
      end
      wr(i_md + 8'h2, 8'h00);
   endtask
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'h1;
      t_regs();
      t_capture();
      t_pwm();
      t_hso();
      t_toggle_on_pulse_match();
      t_fifo();
      report_and_stop();
   end
endmodule
bind ccp_top ccp_monitor u_mon (
   .hclk(hclk),
   .hresetn(hresetn),
   .hsel(hsel),
   .htrans(htrans),
   .hwrite(hwrite),
   .hready(hready),
   .hrdata(hrdata),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .base_counter_high(base_counter_high),
   .base_counter_low(base_counter_low),
   .timer0_overflow(timer0_overflow),
   .timer1_overflow(timer1_overflow),
   .timer3_overflow(timer3_overflow),
   .serial0_timer_overflow(serial0_timer_overflow),
   .module_io_pin_out(module_io_pin_out),
   .module_io_pin_oe(module_io_pin_oe),
   .module_irq(module_irq),
   .dead_time_pair(dead_time_pair)
);
